// ### verilog/link_quality_variance_regs.sv
// Purpose: variance sum readout and link-quality monitor register logic
// Assumes: one core clock, plain register port, same-clock receiver inputs
// Notes:   reads answer one cycle after the read strobe
`timescale 1ns/1ps

// Function
// - hold 32-bit variance sum, valid while ready
// - after freeze: first read low, second high
// - second data read clears ready and freeze
// - monitor enable bit 15, needs 100 Mb link
// - threshold at max/min disables its comparison
// - violation raises interrupt when enabled
// - monitor register read clears flags, re-arms interrupt
// - frequency control/offset flags bits 9..6, clear-on-read
// - wander, gain, equalizer flags bits 5..0
// - monitor bits 14:10 read zero, ignore writes
// - optional automatic 100 Mb link restart
module link_quality_variance_regs
	import lqv_pkg::*;
#(
	parameter int NP = N_PARAM,
	parameter int PW = PARAM_W
) (
	// clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_clk_en,
	// register port
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [DATA_W-1:0] o_rdata,
	// variance computation
	input  wire logic [VAR_W-1:0]  i_var_sum,
	input  wire logic              i_var_load,
	output logic                   o_var_enable,
	output logic [VC_TIMER_W-1:0]  o_var_timer,
	output logic                   o_var_restart,
	// receiver parameters and thresholds
	input  wire logic              i_link_100_ok,
	input  wire logic [NP*PW-1:0]  i_param,
	input  wire logic [NP*PW-1:0]  i_thr_hi,
	input  wire logic [NP*PW-1:0]  i_thr_lo,
	// monitor status
	output logic                   o_monitor_active,
	output logic                   o_link_restart,
	output logic                   o_irq
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [VAR_W-1:0]      var_data;
		logic                  var_ready;
		logic                  var_freeze;
		logic [VC_TIMER_W-1:0] var_timer;
		logic                  var_enable;
		var_rd_t               var_rd;
		logic                  var_restart;
		logic                  monitor_enable_bit;
		logic [2*NP-1:0]       flags;
		logic                  armed;
		logic [IRQ_W-1:0]      irq_stat;
		logic [IRQ_W-1:0]      irq_en;
		logic                  auto_restart;
		logic                  link_restart;
		logic [DATA_W-1:0]     rdata;
	} state_t;

	state_t          q;
	state_t          d;
	logic [1:0]      rst_sync_q;
	logic            rst_n_q;
	logic [2*NP-1:0] viol;
	logic [2*NP-1:0] lq_set;
	logic            mon_active;
	logic            rd_var;
	logic            rd_lqm;
	logic            wr_vc;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// sticky bits: a set in the clearing cycle survives
	function automatic logic [2*NP-1:0] sticky(input logic [2*NP-1:0] cur,
	                                           input logic [2*NP-1:0] set,
	                                           input logic [2*NP-1:0] clr);
		sticky = (cur & ~clr) | set;
	endfunction

	function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] ofs);
		hit = strobe && (i_addr == ofs);
	endfunction

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync_q <= 2'h0;
		end else if (i_clk_en) begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n_q = rst_sync_q[1];

	// ------------------------------------------------------------
	// threshold compare
	// ------------------------------------------------------------
	lq_threshold_cmp #(
		.NP (NP),
		.PW (PW)
	) u_cmp (
		.i_param  (i_param),
		.i_thr_hi (i_thr_hi),
		.i_thr_lo (i_thr_lo),
		.o_viol   (viol)
	);

	// monitoring counts only on a live 100 Mb link
	assign mon_active = q.monitor_enable_bit && i_link_100_ok;
	assign lq_set     = mon_active ? viol : '0;
	assign rd_var     = hit(i_rd, VAR_DATA_OFS);
	assign rd_lqm     = hit(i_rd, LQM_OFS);
	assign wr_vc      = hit(i_wr, VAR_CTRL_OFS);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		d             = q;
		d.var_restart = 1'b0;
		d.link_restart = 1'b0;

		// variance capture, held off while frozen
		if (i_var_load && !q.var_freeze) begin
			d.var_data  = i_var_sum;
			d.var_ready = 1'b1;
		end

		// control writes
		if (wr_vc) begin
			d.var_freeze = i_wdata[VC_FREEZE_BIT];
			d.var_enable = i_wdata[VC_ENABLE_BIT];
			d.var_timer  = i_wdata[VC_TIMER_LSB +: VC_TIMER_W];
			// every control write restarts the computation, whether or not the timer value changes
			d.var_restart = 1'b1;
			if (i_wdata[VC_FREEZE_BIT] && !q.var_freeze) begin
				d.var_rd = VR_LOW;
			end
		end
		if (hit(i_wr, LQM_OFS)) begin
			// only the enable is writable; reserved bits drop
			d.monitor_enable_bit = i_wdata[MONITOR_ENABLE_BIT_BIT];
		end
		if (hit(i_wr, IRQ_EN_OFS)) begin
			d.irq_en = i_wdata[IRQ_W-1:0];
		end
		if (hit(i_wr, AUX_CTRL_OFS)) begin
			d.auto_restart = i_wdata[AUX_RESTART_BIT];
		end

		// data half pointer
		if (rd_var) begin
			case (q.var_rd)
				VR_LOW: begin
					d.var_rd = VR_HIGH;
				end
				VR_HIGH: begin
					d.var_rd     = VR_LOW;
					d.var_ready  = 1'b0;
					d.var_freeze = 1'b0;
				end
				default: begin
					d.var_rd = VR_LOW;
				end
			endcase
		end

		// warning flags: sticky, clear-on-read, set wins
		d.flags = sticky(q.flags, lq_set, rd_lqm ? '1 : '0);

		// interrupt status
		d.irq_stat = q.irq_stat;
		if (hit(i_wr, IRQ_CLR_OFS)) begin
			d.irq_stat = q.irq_stat & ~i_wdata[IRQ_W-1:0];
		end
		if (i_var_load && !q.var_freeze) begin
			d.irq_stat[IRQ_VAR_BIT] = 1'b1;
		end
		// one event per arming; the monitor read re-arms
		if (rd_lqm) begin
			d.armed = 1'b1;
		end
		if (q.armed && (lq_set != '0)) begin
			d.irq_stat[IRQ_LQ_BIT] = 1'b1;
			d.armed                = 1'b0;
			d.link_restart         = q.auto_restart;
		end

		// read data, answered in the following cycle
		d.rdata = RDATA_RST;
		if (i_rd) begin
			case (i_addr)
				VAR_CTRL_OFS: begin
					d.rdata[VC_READY_BIT]                = q.var_ready;
					d.rdata[VC_FREEZE_BIT]               = q.var_freeze;
					d.rdata[VC_TIMER_LSB +: VC_TIMER_W]  = q.var_timer;
					d.rdata[VC_ENABLE_BIT]               = q.var_enable;
				end
				VAR_DATA_OFS: begin
					d.rdata = (q.var_rd == VR_HIGH) ? q.var_data[VAR_W-1:DATA_W]
					                                : q.var_data[DATA_W-1:0];
				end
				LQM_OFS: begin
					d.rdata[MONITOR_ENABLE_BIT_BIT] = q.monitor_enable_bit;
					d.rdata[2*NP-1:0]       = q.flags;
				end
				IRQ_STAT_OFS: begin
					d.rdata[IRQ_W-1:0] = q.irq_stat;
				end
				IRQ_EN_OFS: begin
					d.rdata[IRQ_W-1:0] = q.irq_en;
				end
				AUX_CTRL_OFS: begin
					d.rdata[AUX_RESTART_BIT] = q.auto_restart;
				end
				default: begin
					d.rdata = RDATA_RST;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			q          <= '0;
			q.var_data <= VAR_DATA_RST;
			q.flags    <= FLAGS_RST;
			q.rdata    <= RDATA_RST;
			q.var_rd   <= VR_LOW;
			q.armed    <= 1'b1;
		end else if (i_clk_en) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_rdata          = q.rdata;
	assign o_var_enable     = q.var_enable;
	assign o_var_timer      = q.var_timer;
	assign o_var_restart    = q.var_restart;
	assign o_monitor_active = mon_active;
	assign o_link_restart   = q.link_restart;
	assign o_irq            = |(q.irq_stat & q.irq_en);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!rst_n_q);

	sequence s_low_read;
		i_clk_en && rd_var && (q.var_rd == VR_LOW);
	endsequence

	sequence s_high_read;
		i_clk_en && rd_var && (q.var_rd == VR_HIGH);
	endsequence

	AST_VAR_LOAD: assert property (
		(i_clk_en && i_var_load && !q.var_freeze) |=>
		(q.var_ready && (q.var_data == $past(i_var_sum))))
		else $error("variance load not captured");

	AST_VAR_FROZEN: assert property (
		(i_clk_en && q.var_freeze && !wr_vc) |=> $stable(q.var_data))
		else $error("variance data changed while frozen");

	// a gap of a few cycles between the two halves is allowed
	AST_VAR_HALVES: assert property (
		(s_low_read ##[1:4] s_high_read) |=>
		(o_rdata == $past(q.var_data[VAR_W-1:DATA_W])))
		else $error("variance halves out of order");

	AST_VAR_LOW_FIRST: assert property (
		s_low_read |=> (o_rdata == $past(q.var_data[DATA_W-1:0])))
		else $error("first variance read not low half");

	AST_VAR_AUTOCLR: assert property (
		s_high_read |=> (!q.var_ready && !q.var_freeze && (q.var_rd == VR_LOW)))
		else $error("ready or freeze not cleared after two reads");

	AST_LQM_RSVD: assert property (
		(i_clk_en && rd_lqm) |=> (o_rdata[LQM_RSVD_MSB:LQM_RSVD_LSB] == '0))
		else $error("reserved monitor bits not zero");

	AST_MONITOR_ENABLE_BIT_RD: assert property (
		(i_clk_en && rd_lqm) |=> (o_rdata[MONITOR_ENABLE_BIT_BIT] == $past(q.monitor_enable_bit)))
		else $error("monitor enable read back wrong");

	AST_FLAG_RD: assert property (
		(i_clk_en && rd_lqm) |=> (o_rdata[2*NP-1:0] == $past(q.flags)))
		else $error("warning flags read back wrong");

	AST_VAR_READY_RD: assert property (
		(i_clk_en && hit(i_rd, VAR_CTRL_OFS)) |=> (o_rdata[VC_READY_BIT] == $past(q.var_ready)))
		else $error("variance ready read back wrong");

	AST_NO_FLAG_IDLE: assert property (
		(i_clk_en && !mon_active) |=> ((q.flags & ~$past(q.flags)) == '0))
		else $error("flag set while monitor inactive");

	AST_FLAG_SET_WINS: assert property (
		(i_clk_en && (lq_set != '0)) |=> ((q.flags & $past(lq_set)) == $past(lq_set)))
		else $error("violation lost");

	AST_FLAG_STICKY: assert property (
		(i_clk_en && !rd_lqm) |=> ((q.flags & $past(q.flags)) == $past(q.flags)))
		else $error("flag cleared without read");

	AST_COR_REARM: assert property (
		(i_clk_en && rd_lqm && (lq_set == '0)) |=> ((q.flags == '0) && q.armed))
		else $error("monitor read did not clear and re-arm");

	AST_IRQ_RAISE: assert property (
		(i_clk_en && q.armed && (lq_set != '0) && q.irq_en[IRQ_LQ_BIT]) |=>
		(o_irq && !q.armed))
		else $error("violation did not raise interrupt");

	AST_AUTO_RESTART: assert property (
		(i_clk_en && q.armed && (lq_set != '0)) |=> (o_link_restart == $past(q.auto_restart)))
		else $error("link restart not matching auto restart");

	AST_HI_AT_MAX: assert property (
		(i_thr_hi[PW-1:0] == {PW{1'b1}}) |-> !viol[1])
		else $error("full-scale high threshold flagged");
endmodule // link_quality_variance_regs

// ### verilog/lqv_pkg.sv
// Purpose: shared constants for the variance readout and link-quality monitor
// Assumes: 16-bit management registers, 5-bit register address
// Notes:   own status/clear/enable/aux registers sit at 0x10..0x13
package lqv_pkg;
	// ------------------------------------------------------------
	// bus and widths
	// ------------------------------------------------------------
	localparam int ADDR_W     = 5;
	localparam int DATA_W     = 16;
	localparam int VAR_W      = 32;
	localparam int N_PARAM    = 5;
	localparam int PARAM_W    = 8;
	localparam int FLAG_W     = 2 * N_PARAM;
	localparam int IRQ_W      = 2;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 5'h10;
	localparam logic [ADDR_W-1:0] IRQ_CLR_OFS  = 5'h11;
	localparam logic [ADDR_W-1:0] IRQ_EN_OFS   = 5'h12;
	localparam logic [ADDR_W-1:0] AUX_CTRL_OFS = 5'h13;
	localparam logic [ADDR_W-1:0] VAR_CTRL_OFS = 5'h1a;
	localparam logic [ADDR_W-1:0] VAR_DATA_OFS = 5'h1b;
	localparam logic [ADDR_W-1:0] LQM_OFS      = 5'h1d;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int VC_READY_BIT   = 15;
	localparam int VC_FREEZE_BIT  = 3;
	localparam int VC_TIMER_LSB   = 1;
	localparam int VC_TIMER_W     = 2;
	localparam int VC_ENABLE_BIT  = 0;
	localparam int MONITOR_ENABLE_BIT_BIT = 15;
	localparam int LQM_RSVD_MSB   = 14;
	localparam int LQM_RSVD_LSB   = 10;
	localparam int IRQ_LQ_BIT     = 0;
	localparam int IRQ_VAR_BIT    = 1;
	localparam int AUX_RESTART_BIT = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [VAR_W-1:0]  VAR_DATA_RST = 32'h0000_0000;
	localparam logic [FLAG_W-1:0] FLAGS_RST    = 10'h000;
	localparam logic [DATA_W-1:0] RDATA_RST    = 16'h0000;

	// ------------------------------------------------------------
	// variance readout half pointer
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		VR_LOW  = 2'b01,
		VR_HIGH = 2'b10
	} var_rd_t;
endpackage

// ### verilog/lq_threshold_cmp.sv
// Purpose: high/low threshold comparison for the monitored receiver parameters
// Assumes: unsigned parameter and threshold values, same clock as the user
// Notes:   output bit 2k is param k low, bit 2k+1 is param k high
`timescale 1ns/1ps
module lq_threshold_cmp
	import lqv_pkg::*;
#(
	parameter int NP = N_PARAM,
	parameter int PW = PARAM_W
) (
	// parameter values and thresholds, param k in bits [k*PW +: PW]
	input  wire logic [NP*PW-1:0] i_param,
	input  wire logic [NP*PW-1:0] i_thr_hi,
	input  wire logic [NP*PW-1:0] i_thr_lo,
	// violations
	output logic      [2*NP-1:0]  o_viol
);
	// ------------------------------------------------------------
	// compare
	// ------------------------------------------------------------
	// strict compares: a high threshold at full scale or a low threshold at zero can never be crossed
	always_comb begin
		o_viol = '0;
		for (int k = 0; k < NP; k++) begin
			o_viol[2*k]   = i_param[k*PW +: PW] < i_thr_lo[k*PW +: PW];
			o_viol[2*k+1] = i_param[k*PW +: PW] > i_thr_hi[k*PW +: PW];
		end
	end
endmodule // lq_threshold_cmp

// ### test/link_quality_variance_regs_bench.sv
// Purpose: self-checking bench for the variance readout and link-quality monitor
// Assumes: clock enable high except in the hold scenario; params driven at ports
// Notes:   every task starts and ends just after a rising edge
`timescale 1ns/1ps
module link_quality_variance_regs_bench;
	import lqv_pkg::*;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic              clk;
	logic              rst_n;
	logic              clk_en;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] rdata;
	logic [VAR_W-1:0]  var_sum;
	logic              var_load;
	logic              var_enable;
	logic [1:0]        var_timer;
	logic              var_restart;
	logic              link_ok;
	logic [39:0]       prm;
	logic [39:0]       thi;
	logic [39:0]       tlo;
	logic              mon_active;
	logic              link_restart;
	logic              irq;
	int                err_total;
	int                checks_done;
	int                restarts;
	int                var_restarts;

	link_quality_variance_regs uut (
		.i_core_clk      (clk),
		.i_rst_n         (rst_n),
		.i_clk_en        (clk_en),
		.i_addr          (addr),
		.i_wdata         (wdata),
		.i_wr            (wr),
		.i_rd            (rd),
		.o_rdata         (rdata),
		.i_var_sum       (var_sum),
		.i_var_load      (var_load),
		.o_var_enable    (var_enable),
		.o_var_timer     (var_timer),
		.o_var_restart   (var_restart),
		.i_link_100_ok   (link_ok),
		.i_param         (prm),
		.i_thr_hi        (thi),
		.i_thr_lo        (tlo),
		.o_monitor_active(mon_active),
		.o_link_restart  (link_restart),
		.o_irq           (irq)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// one-cycle pulses are counted, not sampled
	always @(posedge clk) begin
		if (link_restart === 1'b1) begin
			restarts = restarts + 1;
		end
		if (var_restart === 1'b1) begin
			var_restarts = var_restarts + 1;
		end
	end

	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask

	// gap cycle after each strobe avoids double assignment in one step
	task automatic reg_wr(input logic [4:0] a, input logic [15:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic reg_chk(input logic [4:0] a, input logic [15:0] exp);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, exp);
		@(posedge clk);
	endtask

	// param k low threshold for even b, high for odd b
	task automatic viol(input int b);
		if (b[0]) begin
			thi[(b/2)*8 +: 8] <= 8'h7f;
		end else begin
			tlo[(b/2)*8 +: 8] <= 8'h81;
		end
		repeat (2) @(posedge clk);
		thi <= {5{8'hff}};
		tlo <= 40'h0;
		repeat (2) @(posedge clk);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		reg_chk(LQM_OFS, 16'h0000);
		reg_chk(VAR_CTRL_OFS, 16'h0000);
		reg_chk(5'h05, 16'h0000);
		check({15'h0, irq}, 16'h0000);
	endtask

	task automatic t_variance;
		var_sum  <= 32'h89ab_cdef;
		var_load <= 1'b1;
		@(posedge clk);
		var_load <= 1'b0;
		@(posedge clk);
		reg_chk(VAR_CTRL_OFS, 16'h8000);
		reg_wr(VAR_CTRL_OFS, 16'h000f);
		#1 check({13'h0, var_timer, var_enable}, 16'h0007);
		check(var_restarts[15:0], 16'h0001);
		@(posedge clk);
		// freeze must hold off this load
		var_sum  <= 32'h1234_5678;
		var_load <= 1'b1;
		@(posedge clk);
		var_load <= 1'b0;
		@(posedge clk);
		reg_chk(VAR_DATA_OFS, 16'hcdef);
		reg_chk(VAR_DATA_OFS, 16'h89ab);
		reg_chk(VAR_CTRL_OFS, 16'h0007);
		reg_chk(IRQ_STAT_OFS, 16'h0002);
		reg_wr(IRQ_CLR_OFS, 16'h0002);
		reg_chk(IRQ_STAT_OFS, 16'h0000);
	endtask

	task automatic t_flags;
		reg_wr(IRQ_EN_OFS, 16'h0001);
		reg_wr(AUX_CTRL_OFS, 16'h0001);
		reg_chk(IRQ_EN_OFS, 16'h0001);
		reg_chk(AUX_CTRL_OFS, 16'h0001);
		reg_wr(LQM_OFS, 16'hffff);
		reg_chk(LQM_OFS, 16'h8000);
		check({15'h0, mon_active}, 16'h0001);
		prm <= {5{8'hff}};
		repeat (3) @(posedge clk);
		prm <= {5{8'h00}};
		repeat (3) @(posedge clk);
		prm <= {5{8'h80}};
		@(posedge clk);
		reg_chk(LQM_OFS, 16'h8000);
		for (int b = 0; b < 10; b++) begin
			viol(b);
			#1 check({15'h0, irq}, 16'h0001);
			@(posedge clk);
			reg_chk(LQM_OFS, 16'h8000 | (16'h0001 << b));
			reg_chk(LQM_OFS, 16'h8000);
			check(restarts[15:0], 16'(b + 1));
			reg_wr(IRQ_CLR_OFS, 16'h0001);
			#1 check({15'h0, irq}, 16'h0000);
			@(posedge clk);
		end
	endtask

	task automatic t_sticky;
		thi[7:0] <= 8'h7f;
		repeat (2) @(posedge clk);
		reg_chk(LQM_OFS, 16'h8002);
		reg_chk(LQM_OFS, 16'h8002);
		thi <= {5{8'hff}};
		repeat (2) @(posedge clk);
		reg_chk(LQM_OFS, 16'h8002);
		reg_chk(LQM_OFS, 16'h8000);
		reg_wr(IRQ_CLR_OFS, 16'h0001);
	endtask

	task automatic t_gating;
		link_ok <= 1'b0;
		@(posedge clk);
		#1 check({15'h0, mon_active}, 16'h0000);
		@(posedge clk);
		viol(3);
		reg_chk(LQM_OFS, 16'h8000);
		link_ok <= 1'b1;
		reg_wr(LQM_OFS, 16'h0000);
		viol(4);
		reg_chk(LQM_OFS, 16'h0000);
		reg_wr(LQM_OFS, 16'h8000);
		reg_wr(IRQ_EN_OFS, 16'h0000);
		viol(8);
		#1 check({15'h0, irq}, 16'h0000);
		@(posedge clk);
		reg_chk(IRQ_STAT_OFS, 16'h0001);
	endtask

	// strobes while the clock enable is low must be ignored
	task automatic t_hold;
		clk_en <= 1'b0;
		reg_wr(IRQ_EN_OFS, 16'h0001);
		clk_en <= 1'b1;
		reg_chk(IRQ_EN_OFS, 16'h0000);
	endtask

	// ------------------------------------------------------------
	// sequence and verdict
	// ------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		err_total = 0;
		checks_done = 0;
		restarts = 0;
		var_restarts = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		addr = '0;
		wdata = '0;
		wr = 1'b0;
		rd = 1'b0;
		var_sum = '0;
		var_load = 1'b0;
		link_ok = 1'b1;
		prm = {5{8'h80}};
		thi = {5{8'hff}};
		tlo = 40'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_variance();
		t_flags();
		t_sticky();
		t_gating();
		t_hold();
		wrap_up();
	end

	// whole run is well under 2000 cycles
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end
endmodule // link_quality_variance_regs_bench
